// file: rtl/uic_pkg.sv
package uic_pkg;

  // ==========================================================
  // register port
  // ==========================================================
  localparam int            ADDR_W           = 2;
  localparam logic [1:0]    ADDR_ISR_FCR     = 2'h0;
  localparam logic [1:0]    ADDR_LCR         = 2'h1;
  localparam logic [7:0]    RDATA_UNMAPPED   = 8'h00;

  // ==========================================================
  // fifo geometry and reset timing
  // ==========================================================
  localparam int            LVL_W            = 7;
  localparam logic [6:0]    FIFO_DEPTH       = 7'h40;
  localparam logic [1:0]    FIFO_RST_CLKS    = 2'h3;

  // ==========================================================
  // fifo control fields
  // ==========================================================
  localparam int            FCR_EN_BIT       = 0;
  localparam int            FCR_RXRST_BIT    = 1;
  localparam int            FCR_TXRST_BIT    = 2;
  localparam int            FCR_TXTRIG_LSB   = 4;
  localparam int            FCR_RXTRIG_LSB   = 6;
  localparam logic [1:0]    TRIG_SEL_RESET   = 2'h0;

  localparam logic [6:0]    TX_TRIG_L0       = 7'h08;
  localparam logic [6:0]    TX_TRIG_L1       = 7'h10;
  localparam logic [6:0]    TX_TRIG_L2       = 7'h20;
  localparam logic [6:0]    TX_TRIG_L3       = 7'h38;
  localparam logic [6:0]    RX_TRIG_L0       = 7'h08;
  localparam logic [6:0]    RX_TRIG_L1       = 7'h10;
  localparam logic [6:0]    RX_TRIG_L2       = 7'h38;
  localparam logic [6:0]    RX_TRIG_L3       = 7'h3C;

  // ==========================================================
  // line format fields
  // ==========================================================
  localparam logic [7:0]    LCR_RESET        = 8'h1D;
  localparam int            LCR_LEN_LSB      = 0;
  localparam int            LCR_STOP_BIT     = 2;
  localparam int            LCR_PAR_EN_BIT   = 3;
  localparam int            LCR_PAR_EVEN_BIT = 4;
  localparam int            LCR_PAR_FORCE_BIT = 5;
  localparam int            LCR_BREAK_BIT    = 6;
  localparam int            LCR_DIV_BIT      = 7;

  // ==========================================================
  // interrupt mask bits and status codes
  // ==========================================================
  localparam int            IER_RX           = 0;
  localparam int            IER_TX           = 1;
  localparam int            IER_LINE         = 2;
  localparam int            IER_MODEM        = 3;
  localparam int            IER_XOFF         = 5;
  localparam int            IER_RTS          = 6;
  localparam int            IER_CTS          = 7;

  localparam logic [5:0]    ISR_CODE_LINE    = 6'h06;
  localparam logic [5:0]    ISR_CODE_TOUT    = 6'h0C;
  localparam logic [5:0]    ISR_CODE_RECEIVE_READY_EVENT   = 6'h04;
  localparam logic [5:0]    ISR_CODE_TRANSMIT_READY_EVENT   = 6'h02;
  localparam logic [5:0]    ISR_CODE_MODEM   = 6'h00;
  localparam logic [5:0]    ISR_CODE_GPIO    = 6'h30;
  localparam logic [5:0]    ISR_CODE_XOFF    = 6'h10;
  localparam logic [5:0]    ISR_CODE_FLOW    = 6'h20;
  localparam logic [5:0]    ISR_CODE_NONE    = 6'h01;
  localparam logic [7:0]    ISR_RESET        = 8'h01;

endpackage

// file: rtl/uic_trig_cmp.sv
`timescale 1ns/1ps
module uic_trig_cmp
  import uic_pkg::*;
#(
  parameter logic [LVL_W-1:0] LEVEL0 = TX_TRIG_L0,
  parameter logic [LVL_W-1:0] LEVEL1 = TX_TRIG_L1,
  parameter logic [LVL_W-1:0] LEVEL2 = TX_TRIG_L2,
  parameter logic [LVL_W-1:0] LEVEL3 = TX_TRIG_L3
) (
  input  wire logic [1:0]       sel,
  input  wire logic [LVL_W-1:0] count,
  output logic                  above
);

  logic [LVL_W-1:0] level;

  assign level = (sel == 2'h0) ? LEVEL0 :
                 (sel == 2'h1) ? LEVEL1 :
                 (sel == 2'h2) ? LEVEL2 : LEVEL3;
  assign above = (count > level);

endmodule // uic_trig_cmp

// file: rtl/uic_ctrl.sv
`timescale 1ns/1ps
module uic_ctrl
  import uic_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic              regWr,
  input  wire logic              regRd,
  input  wire logic [7:0]        regWdata,
  output logic [7:0]             regRdata,
  input  wire logic [7:0]        interruptMask,
  input  wire logic              enhancedEnable,
  input  wire logic              lineErrPending,
  input  wire logic              rxTimeout,
  input  wire logic [LVL_W-1:0]  rxLevel,
  input  wire logic [LVL_W-1:0]  txLevel,
  input  wire logic              modemChange,
  input  wire logic              gpioChange,
  input  wire logic              xoffMatch,
  input  wire logic              xonMatch,
  input  wire logic              specialMatch,
  input  wire logic              ctsDeassert,
  input  wire logic              rtsDeassert,
  input  wire logic              msrRead,
  input  wire logic              thrWrite,
  output logic [7:0]             isrData,
  output logic                   fifoEnable,
  output logic                   rxFifoReset,
  output logic                   txFifoReset,
  output logic                   rxReadyEvent,
  output logic                   txReadyEvent,
  output logic [1:0]             wordLenSel,
  output logic                   stopLong,
  output logic                   parityEnable,
  output logic                   parityEven,
  output logic                   parityForced,
  output logic                   breakEnable,
  output logic                   divisorSelect
);

  // ==========================================================
  // register strobes
  // ==========================================================
  logic       isrRead;
  logic       fcrWrite;
  logic       fcrApply;
  logic       lcrWrite;
  logic       lcrRead;

  assign isrRead  = regRd && (regAddr == ADDR_ISR_FCR);
  assign fcrWrite = regWr && (regAddr == ADDR_ISR_FCR);
  assign lcrWrite = regWr && (regAddr == ADDR_LCR);
  assign lcrRead  = regRd && (regAddr == ADDR_LCR);
  // other fields only land when the same write keeps the enable set
  assign fcrApply = fcrWrite && regWdata[FCR_EN_BIT];

  // ==========================================================
  // fifo control
  // ==========================================================
  logic       fifoEn_q;
  logic [1:0] txTrigSel_q;
  logic [1:0] rxTrigSel_q;
  logic [1:0] rxRstCnt_q;
  logic [1:0] txRstCnt_q;
  logic       rxRstLoad;
  logic       txRstLoad;
  logic       rxRst_q;
  logic       txRst_q;

  // bit 3 is accepted on the write and simply never stored
  assign rxRstLoad = fcrApply && regWdata[FCR_RXRST_BIT];
  assign txRstLoad = fcrApply && regWdata[FCR_TXRST_BIT];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fifoEn_q    <= 1'b0;
      txTrigSel_q <= TRIG_SEL_RESET;
      rxTrigSel_q <= TRIG_SEL_RESET;
    end else if (fcrWrite) begin
      fifoEn_q <= regWdata[FCR_EN_BIT];
      if (fcrApply) begin
        rxTrigSel_q <= regWdata[FCR_RXTRIG_LSB +: 2];
        if (enhancedEnable) begin
          txTrigSel_q <= regWdata[FCR_TXTRIG_LSB +: 2];
        end
      end
    end
  end

  // reset pulses are held for the full crystal-clock count, then drop
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rxRstCnt_q <= 2'h0;
      txRstCnt_q <= 2'h0;
      rxRst_q    <= 1'b0;
      txRst_q    <= 1'b0;
    end else begin
      rxRstCnt_q <= rxRstLoad ? FIFO_RST_CLKS : (rxRstCnt_q - {1'b0, |rxRstCnt_q});
      txRstCnt_q <= txRstLoad ? FIFO_RST_CLKS : (txRstCnt_q - {1'b0, |txRstCnt_q});
      rxRst_q    <= rxRstLoad || (rxRstCnt_q > 2'h1);
      txRst_q    <= txRstLoad || (txRstCnt_q > 2'h1);
    end
  end

  // ==========================================================
  // trigger compare
  // ==========================================================
  logic [LVL_W-1:0] txSpaces;
  logic             txAbove;
  logic             rxAbove;
  logic             txEmpty;
  logic             rxCond;

  assign txSpaces = FIFO_DEPTH - txLevel;
  assign txEmpty  = (txLevel == '0);

  uic_trig_cmp #(
    .LEVEL0 (TX_TRIG_L0),
    .LEVEL1 (TX_TRIG_L1),
    .LEVEL2 (TX_TRIG_L2),
    .LEVEL3 (TX_TRIG_L3)
  ) u_tx_trig (
    .sel   (txTrigSel_q),
    .count (txSpaces),
    .above (txAbove)
  );

  uic_trig_cmp #(
    .LEVEL0 (RX_TRIG_L0),
    .LEVEL1 (RX_TRIG_L1),
    .LEVEL2 (RX_TRIG_L2),
    .LEVEL3 (RX_TRIG_L3)
  ) u_rx_trig (
    .sel   (rxTrigSel_q),
    .count (rxLevel),
    .above (rxAbove)
  );

  // without fifos a single held character is enough
  assign rxCond = fifoEn_q ? rxAbove : (rxLevel != '0);

  // ==========================================================
  // sticky interrupt sources
  // ==========================================================
  logic txAbove_q;
  logic txEmpty_q;
  logic ierTx_q;
  logic txSet;
  logic txFlag_q;
  logic xoffSet;
  logic xoffFlag_q;
  logic specialKind_q;
  logic flowSet;
  logic flowFlag_q;

  // a reload that never crossed the trigger still interrupts on empty
  assign txSet = (fifoEn_q && txAbove && !txAbove_q) ||
                 (txEmpty && !txEmpty_q) ||
                 (txEmpty && interruptMask[IER_TX] && !ierTx_q);
  assign xoffSet = (xoffMatch || specialMatch) && enhancedEnable &&
                   interruptMask[IER_XOFF];
  assign flowSet = enhancedEnable &&
                   ((ctsDeassert && interruptMask[IER_CTS]) ||
                    (rtsDeassert && interruptMask[IER_RTS]));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      txAbove_q <= 1'b0;
      txEmpty_q <= 1'b1;
      ierTx_q   <= 1'b0;
    end else begin
      txAbove_q <= txAbove;
      txEmpty_q <= txEmpty;
      ierTx_q   <= interruptMask[IER_TX];
    end
  end

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      txFlag_q      <= 1'b0;
      xoffFlag_q    <= 1'b0;
      specialKind_q <= 1'b0;
      flowFlag_q    <= 1'b0;
    end else begin
      txFlag_q <= txSet || (txFlag_q && !(isrRead || thrWrite));
      if (xoffSet) begin
        xoffFlag_q    <= 1'b1;
        specialKind_q <= specialMatch;
      end else if (specialKind_q ? isrRead : xonMatch) begin
        xoffFlag_q <= 1'b0;
      end
      flowFlag_q <= flowSet || (flowFlag_q && !msrRead);
    end
  end

  // ==========================================================
  // priority encode
  // ==========================================================
  logic       linePend;
  logic       toutPend;
  logic       rxPend;
  logic       txPend;
  logic       modemPend;
  logic       flowPend;
  logic       anyPend;
  logic [5:0] isrCode;
  logic       anyPendHigher;

  assign linePend  = interruptMask[IER_LINE] && lineErrPending;
  assign toutPend  = interruptMask[IER_RX] && rxTimeout;
  assign rxPend    = interruptMask[IER_RX] && rxCond;
  assign txPend    = interruptMask[IER_TX] && txFlag_q;
  assign modemPend = interruptMask[IER_MODEM] && modemChange;
  assign flowPend  = enhancedEnable && flowFlag_q;
  assign anyPend   = linePend || toutPend || rxPend || txPend || modemPend ||
                     gpioChange || xoffFlag_q || flowPend;
  assign anyPendHigher = linePend || toutPend || rxPend || txPend || modemPend ||
                         gpioChange || xoffFlag_q;

  // lower sources wait behind higher ones until those are serviced
  assign isrCode = linePend   ? ISR_CODE_LINE  :
                   toutPend   ? ISR_CODE_TOUT  :
                   rxPend     ? ISR_CODE_RECEIVE_READY_EVENT :
                   txPend     ? ISR_CODE_TRANSMIT_READY_EVENT :
                   modemPend  ? ISR_CODE_MODEM :
                   gpioChange ? ISR_CODE_GPIO  :
                   xoffFlag_q ? ISR_CODE_XOFF  :
                   flowPend   ? ISR_CODE_FLOW  :
                                ISR_CODE_NONE;

  // ==========================================================
  // status, line format and read data
  // ==========================================================
  logic [7:0] isr_q;
  logic [7:0] lcr_q;
  logic [7:0] rdata_q;
  logic       rxEvt_q;
  logic       txEvt_q;
  logic       parityForced_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      isr_q   <= ISR_RESET;
      lcr_q   <= LCR_RESET;
      parityForced_q <= LCR_RESET[LCR_PAR_FORCE_BIT] && LCR_RESET[LCR_PAR_EN_BIT];
      rdata_q <= RDATA_UNMAPPED;
      rxEvt_q <= 1'b0;
      txEvt_q <= 1'b0;
    end else begin
      isr_q   <= {{2{fifoEn_q}}, isrCode};
      rxEvt_q <= rxPend || toutPend;
      txEvt_q <= txPend;
      if (lcrWrite) begin
        lcr_q <= regWdata;
        parityForced_q <= regWdata[LCR_PAR_FORCE_BIT] && regWdata[LCR_PAR_EN_BIT];
      end
      if (isrRead) begin
        rdata_q <= isr_q;
      end else if (lcrRead) begin
        rdata_q <= lcr_q;
      end else if (regRd) begin
        rdata_q <= RDATA_UNMAPPED;
      end
    end
  end

  assign regRdata      = rdata_q;
  assign isrData       = isr_q;
  assign fifoEnable    = fifoEn_q;
  assign rxFifoReset   = rxRst_q;
  assign txFifoReset   = txRst_q;
  assign rxReadyEvent  = rxEvt_q;
  assign txReadyEvent  = txEvt_q;
  assign wordLenSel    = lcr_q[LCR_LEN_LSB +: 2];
  assign stopLong      = lcr_q[LCR_STOP_BIT];
  assign parityEnable  = lcr_q[LCR_PAR_EN_BIT];
  assign parityEven    = lcr_q[LCR_PAR_EVEN_BIT];
  // force only means something while parity is on
  assign parityForced  = parityForced_q;
  assign breakEnable   = lcr_q[LCR_BREAK_BIT];
  assign divisorSelect = lcr_q[LCR_DIV_BIT];

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_rx_rst_start;
    rxRstLoad ##1 !rxRstLoad [*3];
  endsequence

  sequence s_tx_rst_start;
    txRstLoad ##1 !txRstLoad [*3];
  endsequence

  a_none_code: assert property (
    !anyPend |=> (isrData[5:0] == ISR_CODE_NONE))
    else $error("no-pending code wrong");

  a_line_first: assert property (
    linePend |=> (isrData[5:0] == ISR_CODE_LINE) && !isrData[0])
    else $error("line error not highest");

  a_tx_code: assert property (
    (txPend && !linePend && !toutPend && !rxPend) |=> (isrData[5:0] == ISR_CODE_TRANSMIT_READY_EVENT))
    else $error("transmit ready code wrong");

  a_flow_code: assert property (
    (flowPend && !anyPendHigher) |=> (isrData[5:0] == ISR_CODE_FLOW))
    else $error("flow change code wrong");

  a_fifo_status: assert property (
    (fcrWrite && regWdata[FCR_EN_BIT]) |=> ##1 (isrData[7:6] == 2'b11))
    else $error("fifo status bits not set");

  a_rx_reset_len: assert property (
    s_rx_rst_start |-> $past(rxFifoReset, 2) && rxFifoReset ##1 !rxFifoReset)
    else $error("receive fifo reset length wrong");

  a_tx_reset_len: assert property (
    s_tx_rst_start |-> $past(txFifoReset, 2) && txFifoReset ##1 !txFifoReset)
    else $error("transmit fifo reset length wrong");

  a_fcr_gate: assert property (
    (fcrWrite && !regWdata[FCR_EN_BIT]) |=> !fifoEnable && $stable(rxTrigSel_q))
    else $error("fifo fields applied without enable");

  a_txtrig_lock: assert property (
    (fcrWrite && !enhancedEnable) |=> $stable(txTrigSel_q))
    else $error("transmit trigger written while locked");

  a_tx_clear: assert property (
    ((isrRead || thrWrite) && !txSet) |=> !txFlag_q)
    else $error("transmit ready not cleared");

  a_xoff_gate: assert property (
    (!xoffFlag_q && !(enhancedEnable && interruptMask[IER_XOFF])) |=> !xoffFlag_q)
    else $error("xoff flag set while gated");

endmodule // uic_ctrl

// file: verification/uic_host_model.sv
`timescale 1ns/1ps
module uic_host_model
  import uic_pkg::*;
(
  input  wire logic         ref_clk,
  output logic [ADDR_W-1:0] regAddr,
  output logic              regWr,
  output logic              regRd,
  output logic [7:0]        regWdata
);
  initial begin
    regAddr  = '0;
    regWr    = 1'b0;
    regRd    = 1'b0;
    regWdata = '0;
  end

  // ==========================================================
  // single register access, strobe up for exactly one edge
  // ==========================================================
  // a random idle gap makes the host answer promptly or slowly
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    repeat ($urandom_range(2)) @(negedge ref_clk);
    @(negedge ref_clk);
    regAddr  = a;
    regWdata = d;
    regWr    = wr;
    regRd    = !wr;
    @(negedge ref_clk);
    regWr    = 1'b0;
    regRd    = 1'b0;
    // released lines carry the inverse so a stale value is never trusted
    regAddr  = ~a;
    regWdata = ~d;
  endtask

  // the enable bit always rides along with the other fifo fields
  task automatic fifo_write(input logic [7:0] d);
    access(1'b1, ADDR_ISR_FCR, {d[7:1], 1'b1});
  endtask
endmodule // uic_host_model

// file: verification/uart_irq_fifo_line_control_tb.sv
`timescale 1ns/1ps
module uart_irq_fifo_line_control_tb
  import uic_pkg::*;
();
  localparam logic [6:0] XOFF = 7'h01;
  localparam logic [6:0] XON  = 7'h02;
  localparam logic [6:0] SPEC = 7'h04;
  localparam logic [6:0] CTS  = 7'h08;
  localparam logic [6:0] RTS  = 7'h10;
  localparam logic [6:0] MSRD = 7'h20;
  localparam logic [6:0] THRW = 7'h40;

  logic              ref_clk        = 1'b0;
  logic              rst_n          = 1'b0;
  logic [ADDR_W-1:0] regAddr;
  logic              regWr;
  logic              regRd;
  logic [7:0]        regWdata;
  logic [7:0]        regRdata;
  logic [7:0]        interruptMask  = 8'hFF;
  logic              enhancedEnable = 1'b1;
  logic              lineErrPending = 1'b0;
  logic              rxTimeout      = 1'b0;
  logic [LVL_W-1:0]  rxLevel        = 7'h00;
  logic [LVL_W-1:0]  txLevel        = 7'h40;
  logic              modemChange    = 1'b0;
  logic              gpioChange     = 1'b0;
  logic [6:0]        pul            = 7'h00;
  wire logic         xoffMatch      = pul[0];
  wire logic         xonMatch       = pul[1];
  wire logic         specialMatch   = pul[2];
  wire logic         ctsDeassert    = pul[3];
  wire logic         rtsDeassert    = pul[4];
  wire logic         msrRead        = pul[5];
  wire logic         thrWrite       = pul[6];
  logic [7:0]        isrData;
  logic              fifoEnable, rxFifoReset, txFifoReset, rxReadyEvent, txReadyEvent;
  logic [1:0]        wordLenSel;
  logic              stopLong, parityEnable, parityEven, parityForced, breakEnable;
  logic              divisorSelect;
  logic              rdTaken        = 1'b0;
  logic [10:0]       expQ[$];
  event              probeEv;
  int                nMismatch      = 0;
  int                totalChecks    = 0;
  int                cycles         = 0;
  logic [6:0]        rxTrig[4]      = '{7'h08, 7'h10, 7'h38, 7'h3C};
  logic [6:0]        txTrig[4]      = '{7'h08, 7'h10, 7'h20, 7'h38};

  uic_ctrl dut (
    .ref_clk, .rst_n, .regAddr, .regWr, .regRd, .regWdata, .regRdata, .interruptMask,
    .enhancedEnable, .lineErrPending, .rxTimeout, .rxLevel, .txLevel, .modemChange,
    .gpioChange, .xoffMatch, .xonMatch, .specialMatch, .ctsDeassert, .rtsDeassert,
    .msrRead, .thrWrite, .isrData, .fifoEnable, .rxFifoReset, .txFifoReset,
    .rxReadyEvent, .txReadyEvent, .wordLenSel, .stopLong, .parityEnable, .parityEven,
    .parityForced, .breakEnable, .divisorSelect
  );

  uic_host_model host (.ref_clk, .regAddr, .regWr, .regRd, .regWdata);

  always #12.5 ref_clk = ~ref_clk;

  // ==========================================================
  // scoreboard: kind 0 read data, 1 status, 2 fifo, 3 format, 4 events
  // ==========================================================
  function automatic logic [7:0] obs(input logic [2:0] k);
    case (k)
      3'h0:    obs = regRdata;
      3'h1:    obs = isrData;
      3'h2:    obs = {5'h00, fifoEnable, rxFifoReset, txFifoReset};
      3'h3:    obs = {divisorSelect, breakEnable, parityForced, parityEven, parityEnable,
                      stopLong, wordLenSel};
      default: obs = {6'h00, rxReadyEvent, txReadyEvent};
    endcase
  endfunction

  task automatic take;
    logic [10:0] e;
    e = expQ.pop_front();
    totalChecks++;
    if (obs(e[10:8]) !== e[7:0]) begin
      nMismatch++;
      $display("Error at %0t: kind %0d expected %h got %h", $time, e[10:8], e[7:0],
               obs(e[10:8]));
    end
  endtask

  always @(posedge ref_clk) rdTaken <= regRd;
  always @(negedge ref_clk) if (rdTaken && expQ.size() > 0) take();
  always @(probeEv) while (expQ.size() > 0 && expQ[0][10:8] != 3'h0) take();

  task automatic results;
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      nMismatch++;
      $display("Error at %0t: run did not finish in time", $time);
      results();
    end
  end

  // ==========================================================
  // stimulus helpers
  // ==========================================================
  task automatic chk(input logic [2:0] k, input logic [7:0] v);
    expQ.push_back({k, v});
    ->probeEv;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    expQ.push_back({3'h0, v});
    host.access(1'b0, a, 8'h00);
    @(negedge ref_clk);
  endtask

  task automatic pulse(input logic [6:0] m);
    pul = m;
    @(negedge ref_clk);
    pul = 7'h00;
  endtask

  // status is one cycle behind its sources, flags may take one more
  task automatic step(input logic [7:0] v);
    repeat (3) @(negedge ref_clk);
    chk(3'h1, v);
  endtask

  task automatic reset_check;
    chk(3'h1, 8'h01);
    chk(3'h2, 8'h00);
    chk(3'h3, 8'h1D);
    chk(3'h4, 8'h00);
    rd(ADDR_LCR, 8'h1D);
    rd(ADDR_ISR_FCR, 8'h01);
    $display("test reset done");
  endtask

  task automatic fifo_reset(input logic [7:0] d, input logic [2:0] hi);
    host.access(1'b1, ADDR_ISR_FCR, d);
    for (int i = 0; i < 4; i++) begin
      chk(3'h2, {5'h00, (i < 3) ? hi : {hi[2], 2'b00}});
      @(negedge ref_clk);
    end
  endtask

  initial begin
    logic [7:0] v;
    void'($urandom(17));
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    reset_check();

    for (int i = 0; i < 8; i++) begin
      v = {5'($urandom), 3'(i)};
      host.access(1'b1, ADDR_LCR, v);
      rd(ADDR_LCR, v);
      chk(3'h3, {v[7:6], v[5] & v[3], v[4:0]});
    end
    host.access(1'b1, 2'h3, 8'hFF);
    rd(2'h2, RDATA_UNMAPPED);
    rd(ADDR_LCR, v);
    $display("test line format done");

    fifo_reset(8'h03, 3'h6);
    fifo_reset(8'h05, 3'h5);
    fifo_reset(8'h07, 3'h7);
    fifo_reset(8'h0E, 3'h0);
    step(8'h01);
    host.fifo_write(8'h09);
    step(8'hC1);
    $display("test fifo control done");

    for (int s = 0; s < 4; s++) begin
      host.fifo_write({2'(s), 2'(s), 1'($urandom), 3'h1});
      rxLevel = rxTrig[s];
      step(8'hC1);
      chk(3'h4, 8'h00);
      rxLevel = rxTrig[s] + 7'h01;
      step(8'hC4);
      chk(3'h4, 8'h02);
      rxLevel = 7'h00;
      txLevel = 7'h40 - txTrig[s];
      step(8'hC1);
      chk(3'h4, 8'h00);
      txLevel = txLevel - 7'h01;
      step(8'hC2);
      chk(3'h4, 8'h01);
      txLevel = 7'h40;
      pulse(THRW);
      step(8'hC1);
    end
    enhancedEnable = 1'b0;
    host.fifo_write(8'h01);
    txLevel = 7'h40 - 7'h09;
    step(8'hC1);
    chk(3'h4, 8'h00);
    txLevel = 7'h40 - 7'h39;
    step(8'hC2);
    chk(3'h4, 8'h01);
    txLevel = 7'h40;
    pulse(THRW);
    enhancedEnable = 1'b1;
    $display("test trigger levels done");

    host.fifo_write(8'h01);
    lineErrPending = 1'b1;
    rxTimeout = 1'b1;
    rxLevel = 7'h09;
    modemChange = 1'b1;
    gpioChange = 1'b1;
    txLevel = 7'h00;
    pulse(XOFF | CTS);
    step(8'hC6);
    lineErrPending = 1'b0;
    step(8'hCC);
    rxTimeout = 1'b0;
    step(8'hC4);
    rxLevel = 7'h00;
    step(8'hC2);
    rd(ADDR_ISR_FCR, 8'hC2);
    step(8'hC0);
    modemChange = 1'b0;
    step(8'hF0);
    gpioChange = 1'b0;
    step(8'hD0);
    pulse(XON);
    step(8'hE0);
    pulse(SPEC);
    step(8'hD0);
    rd(ADDR_ISR_FCR, 8'hD0);
    step(8'hE0);
    pulse(MSRD);
    step(8'hC1);
    enhancedEnable = 1'b0;
    pulse(XOFF | CTS);
    step(8'hC1);
    enhancedEnable = 1'b1;
    pulse(RTS);
    step(8'hE0);
    pulse(MSRD);
    step(8'hC1);
    $display("test priority walk done");

    // a second reset in mid-run, fifo full so no empty edge is seen
    txLevel = 7'h40;
    pulse(THRW);
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    reset_check();
    results();
  end
endmodule // uart_irq_fifo_line_control_tb
